// ==== hdl/ccsd_spi_decoder.sv ====
// Serial command decoder between an SPI master and the register file
`include "ccsd_cfg.svh"

// Overview of operation
// - Bit modify: opcode, address, mask, data
// - Only mask-one bits may change
// - Mask-one bits take the data bit
// - Bit modify only on designated registers
// - Soft reset restores defaults, configuration mode
// - Reset held 128 oscillator cycles
// - Opcode 03 reads from given address
// - Opcode 02 writes from given address
// - Opcodes 1000 0nnn request transmit buffers
// - Opcode a0 returns status byte
// - Sample on rising, drive falling, select low
// - Read address advances after each byte
// - Write byte commits on last bit
// - Request with nnn zero is ignored
module ccsd_spi_decoder
  import ccsd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          cs_n,
  input  wire logic          sck,
  input  wire logic          si,
  output logic               so,
  output logic               so_oe,
  output ccsd_reg_req_t      reg_req,
  input  wire logic [7:0]    reg_rdata,
  input  wire logic [7:0]    status,
  output logic [2:0]         tx_req_set,
  output logic               core_rst
);

  localparam ccsd_state_t CCSD_RST_STATE = '{
    sync1    : `CCSD_SYNC_IDLE,
    sync2    : `CCSD_SYNC_IDLE,
    phase    : CCSD_OPC,
    cmd      : CCSD_CMD_READ,
    rst_cnt  : `CCSD_RST_HOLD_CYC,
    core_rst : 1'b1,
    default  : '0
  };

  ccsd_state_t state_r;
  ccsd_state_t state_nxt;

  logic       cs_hi;
  logic       sck_rise;
  logic       sck_fall;
  logic       si_s;
  logic       out_phase;
  logic [7:0] rx_byte;

  function automatic logic ccsd_bm_ok(input logic [7:0] a);
    ccsd_bm_ok = (a == `CCSD_BM_PINCTL)
              || (a == `CCSD_BM_RTSCTL)
              || (a[3:0] == `CCSD_BM_CTRL_LO)
              || ((a >= `CCSD_BM_INT_FIRST) && (a <= `CCSD_BM_INT_LAST))
              || ((a[3:0] == `CCSD_BM_BUF_LO)
                  && (a[7:4] >= `CCSD_BM_BUF_FIRST)
                  && (a[7:4] <= `CCSD_BM_BUF_LAST));
  endfunction : ccsd_bm_ok

  // Pin levels are only read after the second synchroniser stage
  assign cs_hi     = state_r.sync2[2];
  assign sck_rise  = state_r.sync2[1] & ~state_r.sck_prev;
  assign sck_fall  = ~state_r.sync2[1] & state_r.sck_prev;
  assign si_s      = state_r.sync2[0];
  assign rx_byte   = {state_r.rx_sh[6:0], si_s};
  assign out_phase = (state_r.phase == CCSD_STAT)
                  || ((state_r.phase == CCSD_XFER)
                      && (state_r.cmd == CCSD_CMD_READ));

  always_comb
  begin
    state_nxt            = state_r;
    state_nxt.sync1      = {cs_n, sck, si};
    state_nxt.sync2      = state_r.sync1;
    state_nxt.sck_prev   = state_r.sync2[1];
    state_nxt.req.rd     = 1'b0;
    state_nxt.req.wr     = 1'b0;
    state_nxt.tx_req_set = 3'h0;
    state_nxt.load_pend  = 1'b0;
    // Hold count runs on the oscillator clock, here the system clock
    state_nxt.rst_cnt    = (state_r.rst_cnt != 8'h00)
                         ? state_r.rst_cnt - 8'h01 : 8'h00;
    state_nxt.core_rst   = (state_r.rst_cnt != 8'h00);
    // Register file answers in the cycle the read strobe stands
    if (state_r.load_pend)
    begin
      state_nxt.tx_sh = state_r.load_stat ? status : reg_rdata;
      state_nxt.old   = reg_rdata;
    end
    if (cs_hi)
    begin
      state_nxt.phase   = CCSD_OPC;
      state_nxt.bit_cnt = 3'h0;
      state_nxt.so_oe   = 1'b0;
    end
    else if (state_r.core_rst)
    begin
      // Frame that carried the reset is dropped until deselect
      state_nxt.phase = CCSD_IGNORE;
      state_nxt.so_oe = 1'b0;
    end
    else
    begin
      if (sck_fall && out_phase)
      begin
        state_nxt.so    = state_r.tx_sh[7];
        state_nxt.tx_sh = {state_r.tx_sh[6:0], 1'b0};
        state_nxt.so_oe = 1'b1;
      end
      if (sck_rise)
      begin
        state_nxt.rx_sh   = rx_byte;
        state_nxt.bit_cnt = state_r.bit_cnt + 3'h1;
        // Partial bytes never act: a deselect simply drops them
        if (state_r.bit_cnt == `CCSD_BIT_LAST)
        begin
          unique case (state_r.phase)
            CCSD_OPC:
            begin
              if (rx_byte == `CCSD_OP_READ)
              begin
                state_nxt.cmd   = CCSD_CMD_READ;
                state_nxt.phase = CCSD_ADDR;
              end
              else if (rx_byte == `CCSD_OP_WRITE)
              begin
                state_nxt.cmd   = CCSD_CMD_WRITE;
                state_nxt.phase = CCSD_ADDR;
              end
              else if (rx_byte == `CCSD_OP_BITMOD)
              begin
                state_nxt.cmd   = CCSD_CMD_BITMOD;
                state_nxt.phase = CCSD_ADDR;
              end
              else if (rx_byte == `CCSD_OP_STATUS)
              begin
                state_nxt.phase     = CCSD_STAT;
                state_nxt.load_pend = 1'b1;
                state_nxt.load_stat = 1'b1;
              end
              else if (rx_byte[7:3] == `CCSD_OP_RTS_HI)
              begin
                // An all-zero select sets nothing by itself
                state_nxt.tx_req_set = rx_byte[2:0];
                state_nxt.phase      = CCSD_IGNORE;
              end
              else if (rx_byte == `CCSD_OP_RESET)
              begin
                state_nxt.rst_cnt = `CCSD_RST_HOLD_CYC;
                state_nxt.phase   = CCSD_IGNORE;
              end
              else
              begin
                state_nxt.phase = CCSD_IGNORE;
              end
            end
            CCSD_ADDR:
            begin
              state_nxt.addr     = rx_byte;
              state_nxt.req.addr = rx_byte;
              if (state_r.cmd == CCSD_CMD_WRITE)
              begin
                state_nxt.phase = CCSD_XFER;
              end
              else
              begin
                // Bit modify also fetches the old value for merging
                state_nxt.req.rd    = 1'b1;
                state_nxt.load_pend = 1'b1;
                state_nxt.load_stat = 1'b0;
                state_nxt.phase     = (state_r.cmd == CCSD_CMD_READ)
                                    ? CCSD_XFER : CCSD_MASK;
              end
            end
            CCSD_XFER:
            begin
              state_nxt.addr = state_r.addr + 8'h01;
              if (state_r.cmd == CCSD_CMD_WRITE)
              begin
                state_nxt.req.wr    = 1'b1;
                state_nxt.req.addr  = state_r.addr;
                state_nxt.req.wdata = rx_byte;
              end
              else
              begin
                state_nxt.req.rd    = 1'b1;
                state_nxt.req.addr  = state_r.addr + 8'h01;
                state_nxt.load_pend = 1'b1;
                state_nxt.load_stat = 1'b0;
              end
            end
            CCSD_MASK:
            begin
              state_nxt.mask  = rx_byte;
              state_nxt.phase = CCSD_MODIFY;
            end
            CCSD_MODIFY:
            begin
              state_nxt.phase = CCSD_IGNORE;
              if (ccsd_bm_ok(state_r.addr))
              begin
                state_nxt.req.wr    = 1'b1;
                state_nxt.req.addr  = state_r.addr;
                state_nxt.req.wdata = (state_r.old & ~state_r.mask)
                                    | (rx_byte & state_r.mask);
              end
            end
            CCSD_STAT:
            begin
              // Status repeats for as long as clocks keep coming
              state_nxt.load_pend = 1'b1;
              state_nxt.load_stat = 1'b1;
            end
            CCSD_IGNORE:
            begin
              state_nxt.phase = CCSD_IGNORE;
            end
            default:
            begin
              state_nxt.phase = CCSD_IGNORE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= CCSD_RST_STATE;
    else
      state_r <= state_nxt;
  end

  assign so         = state_r.so;
  assign so_oe      = state_r.so_oe;
  assign reg_req    = state_r.req;
  assign tx_req_set = state_r.tx_req_set;
  assign core_rst   = state_r.core_rst;

endmodule : ccsd_spi_decoder

// ==== hdl/ccsd_cfg.svh ====
// Opcodes, address rules and timing counts of the serial command decoder
`ifndef CCSD_CFG_SVH
`define CCSD_CFG_SVH

`define CCSD_OP_RESET     8'hc0
`define CCSD_OP_READ      8'h03
`define CCSD_OP_WRITE     8'h02
`define CCSD_OP_STATUS    8'ha0
`define CCSD_OP_BITMOD    8'h05
`define CCSD_OP_RTS_HI    5'h10

`define CCSD_BIT_LAST     3'h7
`define CCSD_BYTE_ONES    8'hff

`define CCSD_RST_HOLD_OSC 8'h80
`define CCSD_RST_HOLD_CYC (`CCSD_RST_HOLD_OSC)

`define CCSD_BM_PINCTL    8'h0c
`define CCSD_BM_RTSCTL    8'h0d
`define CCSD_BM_CTRL_LO   4'hf
`define CCSD_BM_INT_FIRST 8'h2b
`define CCSD_BM_INT_LAST  8'h2d
`define CCSD_BM_BUF_LO    4'h0
`define CCSD_BM_BUF_FIRST 4'h3
`define CCSD_BM_BUF_LAST  4'h7

`define CCSD_SYNC_IDLE    3'h4

`endif

// ==== hdl/ccsd_pkg.sv ====
// Types of the serial command decoder
package ccsd_pkg;

  typedef enum logic [2:0]
  {
    CCSD_OPC    = 3'b000,
    CCSD_ADDR   = 3'b001,
    CCSD_XFER   = 3'b010,
    CCSD_MASK   = 3'b011,
    CCSD_MODIFY = 3'b100,
    CCSD_STAT   = 3'b101,
    CCSD_IGNORE = 3'b110
  } ccsd_phase_t;

  typedef enum logic [1:0]
  {
    CCSD_CMD_READ   = 2'b00,
    CCSD_CMD_WRITE  = 2'b01,
    CCSD_CMD_BITMOD = 2'b10
  } ccsd_cmd_t;

  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccsd_reg_req_t;

  typedef struct packed
  {
    logic [2:0]    sync1;
    logic [2:0]    sync2;
    logic          sck_prev;
    ccsd_phase_t   phase;
    ccsd_cmd_t     cmd;
    logic [2:0]    bit_cnt;
    logic [7:0]    rx_sh;
    logic [7:0]    tx_sh;
    logic [7:0]    addr;
    logic [7:0]    mask;
    logic [7:0]    old;
    logic          load_pend;
    logic          load_stat;
    ccsd_reg_req_t req;
    logic [2:0]    tx_req_set;
    logic          so;
    logic          so_oe;
    logic [7:0]    rst_cnt;
    logic          core_rst;
  } ccsd_state_t;

endpackage : ccsd_pkg

// ==== test/ccsd_spi_decoder_chk.sv ====
// Port assertions of the serial command decoder
module ccsd_spi_decoder_chk
  import ccsd_pkg::*;
(
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          cs_n,
  input wire logic          so_oe,
  input wire ccsd_reg_req_t reg_req,
  input wire logic [2:0]    tx_req_set,
  input wire logic          core_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Slack of a few cycles covers the counter start edge
  sequence s_hold;
    ##126 core_rst ##[1:4] !core_rst;
  endsequence
  a_pin_hold: assert property ($fell(sys_rst) |-> s_hold)
    else $error("hold after pin reset wrong");
  a_soft_hold: assert property ($rose(core_rst) |-> s_hold)
    else $error("hold after soft reset wrong");
  a_oe_idle: assert property (cs_n [*5] |-> !so_oe)
    else $error("so driven while deselected");
  a_idle_quiet: assert property (cs_n [*6] |-> !reg_req.wr)
    else $error("write while deselected");
  a_rd_wr_excl: assert property (!(reg_req.rd && reg_req.wr))
    else $error("read and write together");
  a_wr_pulse: assert property (reg_req.wr |=> !reg_req.wr)
    else $error("write pulse too long");
  a_rts_pulse: assert property (tx_req_set != 3'h0 |=>
    tx_req_set == 3'h0) else $error("request pulse too long");
  a_rst_quiet: assert property (core_rst |-> !reg_req.wr &&
    tx_req_set == 3'h0) else $error("side effect in reset");
endmodule : ccsd_spi_decoder_chk

bind ccsd_spi_decoder ccsd_spi_decoder_chk chk_i (.clk(clk),
  .sys_rst(sys_rst), .cs_n(cs_n), .so_oe(so_oe),
  .reg_req(reg_req), .tx_req_set(tx_req_set),
  .core_rst(core_rst));

// ==== test/ccsd_spi_mst.sv ====
// SPI master model, modes 0,0 and 1,1, 64 ns serial clock
module ccsd_spi_mst
(
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cpol = 1'b0;
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b1;
  end
  task automatic open;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask : open
  // Idle level only moves while deselected, so no bit is counted
  task automatic set_idle(input logic lvl);
    cpol = lvl;
    sck  = lvl;
    repeat (6) @(negedge clk);
  endtask : set_idle
  // SO read at end of high phase: it only moves after the next fall
  task automatic shift(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      si  = tx[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      rx  = {rx[6:0], so};
    end
  endtask : shift
  task automatic close;
    sck = cpol;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si   = ~si;
    repeat (6) @(negedge clk);
  endtask : close
endmodule : ccsd_spi_mst

// ==== test/ccsd_spi_decoder_tb_top.sv ====
// Testbench of the serial command decoder
module ccsd_spi_decoder_tb_top
  import ccsd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic [7:0]    stat = 8'h96;
  logic [7:0]    mem [256];
  logic [7:0]    got [$];
  logic [2:0]    rts_seen = 3'h0;
  int            hi_cnt = 0;
  int            err_count = 0;
  int            check_count = 0;
  wire           cs_n, sck, si, so, so_oe, core_rst;
  ccsd_reg_req_t req;
  logic [2:0]    rts;
  wire           so_line;
  wire [7:0]     rdata;
  always #4 clk = ~clk;
  // Released line shows the inverse, so stale data cannot pass
  assign so_line = so_oe ? so : ~so;
  // Read data only valid while the read strobe stands
  assign rdata = req.rd ? mem[req.addr] : ~mem[req.addr];
  ccsd_spi_mst mst (.clk(clk), .so(so_line), .cs_n(cs_n), .sck(sck),
    .si(si));
  ccsd_spi_decoder uut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .reg_req(req), .reg_rdata(rdata), .status(stat),
    .tx_req_set(rts), .core_rst(core_rst));
  always @(posedge clk)
  begin
    if (req.wr === 1'b1)
      mem[req.addr] <= req.wdata;
    rts_seen <= rts_seen | rts;
  end
  always @(negedge clk)
    if (core_rst === 1'b1)
      hi_cnt++;
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic wait_core;
    int i;
    for (i = 0; i < 400 && core_rst !== 1'b0; i++)
      @(negedge clk);
    if (i == 400)
    begin
      err_count++;
      end_sim();
    end
  endtask : wait_core
  // A nonzero part appends that many bits of a byte cut short
  task automatic send(input logic [7:0] q [$], input int part);
    logic [7:0] r;
    got = {};
    mst.open();
    foreach (q[i])
    begin
      mst.shift(q[i], 8, r);
      got.push_back(r);
    end
    if (part > 0)
      mst.shift(8'h33, part, r);
    mst.close();
  endtask : send
  task automatic t_write;
    send({8'h02, 8'h31, 8'h5a, 8'ha5}, 4);
    chk("wr0", 8'h5a, mem[8'h31]);
    chk("wr1", 8'ha5, mem[8'h32]);
    chk("wrcut", 8'h00, mem[8'h33]);
  endtask : t_write
  task automatic t_read;
    send({8'h03, 8'h31, 8'h00, 8'h00}, 0);
    chk("rd0", 8'h5a, got[2]);
    chk("rd1", 8'ha5, got[3]);
  endtask : t_read
  task automatic t_bitmod;
    mem[8'h2c] = 8'hf0;
    send({8'h05, 8'h2c, 8'h3c, 8'h0a}, 0);
    chk("bm", 8'hc8, mem[8'h2c]);
    send({8'h05, 8'h31, 8'hff, 8'h00}, 0);
    chk("bmdeny", 8'h5a, mem[8'h31]);
    send({8'h05, 8'h2c, 8'hff}, 4);
    chk("bmcut", 8'hc8, mem[8'h2c]);
  endtask : t_bitmod
  task automatic t_rts;
    for (int n = 0; n < 8; n++)
    begin
      rts_seen = 3'h0;
      send({8'h80 | 8'(n)}, 0);
      chk("rts", 8'(n), {5'h0, rts_seen});
    end
  endtask : t_rts
  task automatic t_status;
    stat = 8'h69;
    send({8'ha0, 8'h00, 8'h00}, 0);
    chk("st0", 8'h69, got[1]);
    chk("st1", 8'h69, got[2]);
  endtask : t_status
  task automatic t_unknown;
    send({8'hff, 8'h02, 8'h31, 8'h77}, 0);
    chk("unk", 8'h5a, mem[8'h31]);
  endtask : t_unknown
  task automatic t_mode11;
    mst.set_idle(1'b1);
    send({8'h02, 8'h34, 8'h3c}, 0);
    send({8'h03, 8'h34, 8'h00}, 0);
    chk("rd11", 8'h3c, got[2]);
    mst.set_idle(1'b0);
  endtask : t_mode11
  task automatic t_reset;
    hi_cnt = 0;
    send({8'hc0}, 0);
    chk("srst", 8'h01, {7'h0, core_rst});
    wait_core();
    chk("hold", 8'h80, 8'(hi_cnt));
  endtask : t_reset
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    wait_core();
    t_write();
    t_read();
    t_bitmod();
    t_rts();
    t_status();
    t_unknown();
    t_mode11();
    t_reset();
    end_sim();
  end
endmodule : ccsd_spi_decoder_tb_top
